// file: hw/mbs_defines.vh
`ifndef MBS_DEFINES_VH
`define MBS_DEFINES_VH

// clock and sequence timing
`define MBS_CLK_HZ 10000000
`define MBS_BASE_DELAY_MS 200
`define MBS_WAIT_UNIT_MS 100
`define MBS_BASE_DELAY_CYC (`MBS_BASE_DELAY_MS * (`MBS_CLK_HZ / 1000))
`define MBS_WAIT_UNIT_CYC (`MBS_WAIT_UNIT_MS * (`MBS_CLK_HZ / 1000))

// start frequencies for the two select variants
`define MBS_FREQ_FIFTY 7'h32
`define MBS_FREQ_SIXTY 7'h3c

// register offsets (byte addresses)
`define MBS_REG_CTRL 4'h0
`define MBS_REG_WAIT 4'h4
`define MBS_REG_STATUS 4'h8

// control register fields
`define MBS_CTRL_FALLBACK 0
`define MBS_CTRL_MAINS_ASSIGNED 1
`define MBS_CTRL_OUTPUT_ASSIGNED 2
`define MBS_CTRL_INPUT_ASSIGNED 3
`define MBS_CTRL_RESET 4'h0
`define MBS_WAIT_RESET 8'h00

// status register fields
`define MBS_STAT_STATE_LSB 0
`define MBS_STAT_STATE_MSB 7
`define MBS_STAT_MAINS 8
`define MBS_STAT_INPUT 9
`define MBS_STAT_OUTPUT 10
`define MBS_STAT_GATE 11
`define MBS_STAT_SELECT 12
`define MBS_STAT_SIXTY 13

`endif

// file: hw/mbs_delay_timer.v
`include "mbs_defines.vh"

// down counter for one sequence delay; done is a one-cycle pulse
module mbs_delay_timer #(
  parameter CW = 32
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire start,
  input wire abort,
  input wire [CW-1:0] load_val,
  output reg busy_ff,
  output reg done_ff
);

  reg [CW-1:0] count_ff;

  // a start always reloads, so a new step restarts the wait cleanly
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      count_ff <= {CW{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= 1'b0;
      if (start) begin
        count_ff <= (load_val == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : load_val;
        busy_ff <= 1'b1;
      end else if (abort) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        if (count_ff == {{(CW-1){1'b0}}, 1'b1}) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        count_ff <= count_ff - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// file: hw/mbs_sequencer.v
`include "mbs_defines.vh"

module mbs_sequencer #(
  parameter [31:0] BASE_DELAY_CYC = `MBS_BASE_DELAY_CYC,
  parameter [31:0] WAIT_UNIT_CYC = `MBS_WAIT_UNIT_CYC
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire select_drive_mode_fifty,
  input wire select_drive_mode_sixty,
  input wire run_cmd_pin,
  input wire drive_alarm,
  input wire main_circuit_ready,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  output reg [31:0] reg_rd_data_ff,
  output reg mains_contactor_cmd_ff,
  output reg drive_input_contactor_cmd_ff,
  output reg drive_output_contactor_cmd_ff,
  output reg gate_enable_ff,
  output reg drive_run_ff,
  output reg resync_start_ff,
  output reg [6:0] start_freq_hz_ff
);

  // one-hot sequence states
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_MAINS_WAIT = 8'h02;
  localparam [7:0] ST_MAINS = 8'h04;
  localparam [7:0] ST_OUT_WAIT = 8'h08;
  localparam [7:0] ST_OUT_READY = 8'h10;
  localparam [7:0] ST_RESYNC_WAIT = 8'h20;
  localparam [7:0] ST_DRIVE = 8'h40;
  localparam [7:0] ST_ALARM_STOP = 8'h80;

  // software settings
  reg [3:0] ctrl_ff;
  reg [7:0] restart_wait_time_ff;
  wire alarm_mains_fallback_sel;
  wire mains_assigned;
  wire output_assigned;
  wire input_assigned;

  // pin synchronisers, three stages each
  reg [2:0] fifty_sync_ff;
  reg [2:0] sixty_sync_ff;
  reg [2:0] run_sync_ff;
  reg fifty_ff;
  reg sixty_ff;
  reg run_ff;
  reg select_q_ff;

  // sequence state and timer control
  reg [7:0] state_ff;
  reg [7:0] nxt_state;
  reg nxt_mains;
  reg nxt_input;
  reg nxt_output;
  reg nxt_gate;
  reg nxt_run;
  reg nxt_resync;
  reg tmr_start;
  reg tmr_with_wait;
  reg tmr_abort;
  wire tmr_busy;
  wire tmr_done;
  wire [31:0] tmr_load;
  wire select_on;
  wire select_rise;
  wire select_fall;
  wire seq_enable;

  assign alarm_mains_fallback_sel = ctrl_ff[`MBS_CTRL_FALLBACK];
  assign mains_assigned = ctrl_ff[`MBS_CTRL_MAINS_ASSIGNED];
  assign output_assigned = ctrl_ff[`MBS_CTRL_OUTPUT_ASSIGNED];
  assign input_assigned = ctrl_ff[`MBS_CTRL_INPUT_ASSIGNED];

  // either variant selects drive feed; both at once is the user's fault
  assign select_on = fifty_ff | sixty_ff;
  assign select_rise = select_on & ~select_q_ff;
  assign select_fall = ~select_on & select_q_ff;
  assign seq_enable = mains_assigned & output_assigned;

  // delay length: fixed part plus optional restart wait, all in cycles
  assign tmr_load = BASE_DELAY_CYC +
    (tmr_with_wait ? ({24'h000000, restart_wait_time_ff} * WAIT_UNIT_CYC) : 32'h00000000);

  // a change counts once the second and third stages agree
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      fifty_sync_ff <= 3'h0;
      sixty_sync_ff <= 3'h0;
      run_sync_ff <= 3'h0;
      fifty_ff <= 1'b0;
      sixty_ff <= 1'b0;
      run_ff <= 1'b0;
      select_q_ff <= 1'b0;
    end else if (clk_en) begin
      fifty_sync_ff <= {fifty_sync_ff[1:0], select_drive_mode_fifty};
      sixty_sync_ff <= {sixty_sync_ff[1:0], select_drive_mode_sixty};
      run_sync_ff <= {run_sync_ff[1:0], run_cmd_pin};
      if (fifty_sync_ff[1] == fifty_sync_ff[2]) begin
        fifty_ff <= fifty_sync_ff[2];
      end
      if (sixty_sync_ff[1] == sixty_sync_ff[2]) begin
        sixty_ff <= sixty_sync_ff[2];
      end
      if (run_sync_ff[1] == run_sync_ff[2]) begin
        run_ff <= run_sync_ff[2];
      end
      select_q_ff <= select_on;
    end
  end

  // register writes
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_ff <= `MBS_CTRL_RESET;
      restart_wait_time_ff <= `MBS_WAIT_RESET;
    end else if (clk_en && reg_wr_en) begin
      case (reg_addr)
        `MBS_REG_CTRL: begin
          ctrl_ff <= reg_wr_data[3:0];
        end
        `MBS_REG_WAIT: begin
          restart_wait_time_ff <= reg_wr_data[7:0];
        end
        default: begin
          ctrl_ff <= ctrl_ff;
        end
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe; unmapped reads zero
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rd_data_ff <= 32'h00000000;
    end else if (clk_en) begin
      reg_rd_data_ff <= 32'h00000000;
      if (reg_rd_en) begin
        case (reg_addr)
          `MBS_REG_CTRL: begin
            reg_rd_data_ff <= {28'h0000000, ctrl_ff};
          end
          `MBS_REG_WAIT: begin
            reg_rd_data_ff <= {24'h000000, restart_wait_time_ff};
          end
          `MBS_REG_STATUS: begin
            reg_rd_data_ff <= {18'h00000, sixty_ff, select_on, gate_enable_ff,
              drive_output_contactor_cmd_ff, drive_input_contactor_cmd_ff,
              mains_contactor_cmd_ff, state_ff};
          end
          default: begin
            reg_rd_data_ff <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // next state and contactor commands
  always @* begin
    nxt_state = state_ff;
    nxt_mains = mains_contactor_cmd_ff;
    nxt_input = drive_input_contactor_cmd_ff;
    nxt_output = drive_output_contactor_cmd_ff;
    nxt_gate = gate_enable_ff;
    nxt_run = drive_run_ff;
    nxt_resync = 1'b0;
    tmr_start = 1'b0;
    tmr_with_wait = 1'b0;
    tmr_abort = 1'b0;
    if (!seq_enable) begin
      // no switching: plain drive, contactors left open
      nxt_state = ST_IDLE;
      nxt_mains = 1'b0;
      nxt_input = 1'b0;
      nxt_output = 1'b0;
      nxt_gate = run_ff & ~drive_alarm;
      nxt_run = run_ff & ~drive_alarm;
      tmr_abort = 1'b1;
    end else if (select_fall || (state_ff == ST_IDLE && !select_on)) begin
      // go to mains: gate off and drive side open before anything else
      nxt_state = ST_MAINS_WAIT;
      nxt_gate = 1'b0;
      nxt_run = 1'b0;
      nxt_input = 1'b0;
      nxt_output = 1'b0;
      nxt_mains = 1'b0;
      tmr_start = 1'b1;
      tmr_with_wait = 1'b1;
    end else if (select_rise || (state_ff == ST_IDLE && select_on)) begin
      // go to drive: input side first, mains open at once
      nxt_state = ST_OUT_WAIT;
      nxt_input = input_assigned;
      nxt_mains = 1'b0;
      nxt_output = 1'b0;
      nxt_gate = 1'b0;
      nxt_run = 1'b0;
      tmr_start = 1'b1;
    end else begin
      case (state_ff)
        ST_MAINS_WAIT: begin
          // mains closes when the wait ends if a run command stands, or later in ST_MAINS once one arrives
          if (tmr_done) begin
            nxt_state = ST_MAINS;
            nxt_mains = run_ff;
          end
        end
        ST_MAINS: begin
          nxt_mains = run_ff;
          nxt_input = 1'b0;
          nxt_output = 1'b0;
          nxt_gate = 1'b0;
          nxt_run = 1'b0;
        end
        ST_OUT_WAIT: begin
          if (tmr_done) begin
            nxt_state = ST_OUT_READY;
          end
        end
        ST_OUT_READY: begin
          // fixed part done; the rest is however long the main circuit takes
          if (main_circuit_ready) begin
            nxt_state = ST_RESYNC_WAIT;
            nxt_output = 1'b1;
            tmr_start = 1'b1;
            tmr_with_wait = 1'b1;
          end
        end
        ST_RESYNC_WAIT: begin
          if (tmr_done) begin
            nxt_state = ST_DRIVE;
            nxt_resync = 1'b1;
          end
        end
        ST_DRIVE: begin
          nxt_input = input_assigned;
          nxt_output = 1'b1;
          nxt_mains = 1'b0;
          if (drive_alarm && alarm_mains_fallback_sel) begin
            // fallback takes the same path as a falling select
            nxt_state = ST_MAINS_WAIT;
            nxt_gate = 1'b0;
            nxt_run = 1'b0;
            nxt_input = 1'b0;
            nxt_output = 1'b0;
            tmr_start = 1'b1;
            tmr_with_wait = 1'b1;
          end else if (drive_alarm) begin
            nxt_state = ST_ALARM_STOP;
            nxt_gate = 1'b0;
            nxt_run = 1'b0;
          end else begin
            nxt_gate = run_ff;
            nxt_run = run_ff;
          end
        end
        ST_ALARM_STOP: begin
          // stay on the drive side, stopped, until the alarm clears
          nxt_gate = 1'b0;
          nxt_run = 1'b0;
          if (!drive_alarm) begin
            nxt_state = ST_DRIVE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          tmr_abort = 1'b1;
        end
      endcase
    end
  end

  // state and output registers
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      mains_contactor_cmd_ff <= 1'b0;
      drive_input_contactor_cmd_ff <= 1'b0;
      drive_output_contactor_cmd_ff <= 1'b0;
      gate_enable_ff <= 1'b0;
      drive_run_ff <= 1'b0;
      resync_start_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      // mains and output never both asked for here; external interlock still required
      mains_contactor_cmd_ff <= nxt_mains & ~nxt_output;
      drive_input_contactor_cmd_ff <= nxt_input;
      drive_output_contactor_cmd_ff <= nxt_output;
      gate_enable_ff <= nxt_gate;
      drive_run_ff <= nxt_run;
      resync_start_ff <= nxt_resync;
    end
  end

  // start frequency follows the variant seen when select is on
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      start_freq_hz_ff <= `MBS_FREQ_FIFTY;
    end else if (clk_en && select_on) begin
      start_freq_hz_ff <= sixty_ff ? `MBS_FREQ_SIXTY : `MBS_FREQ_FIFTY;
    end
  end

  // single timer serves every step, since the steps never overlap
  mbs_delay_timer #(
    .CW(32)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(tmr_start),
    .abort(tmr_abort),
    .load_val(tmr_load),
    .busy_ff(tmr_busy),
    .done_ff(tmr_done)
  );

endmodule

// file: sim/mains_bypass_switch_sequencer_tb.sv
module mains_bypass_switch_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 20;
  localparam int UNIT = 10;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic select_drive_mode_fifty = 1'b0, select_drive_mode_sixty = 1'b0;
  logic run_cmd_pin = 1'b0, drive_alarm = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic powered = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wr_data = 32'h0;
  wire [31:0] reg_rd_data_ff;
  wire mains_contactor_cmd_ff, drive_input_contactor_cmd_ff, drive_output_contactor_cmd_ff;
  wire gate_enable_ff, drive_run_ff, resync_start_ff, main_circuit_ready, overlap;
  wire [6:0] start_freq_hz_ff;
  int failures = 0, samples_checked = 0, seed = 32'h737e, cyc = 0;
  // bit view: 0 mains, 1 input, 2 output, 3 gate, 4 resync, 5 run
  wire [5:0] o = {drive_run_ff, resync_start_ff, gate_enable_ff,
    drive_output_contactor_cmd_ff, drive_input_contactor_cmd_ff, mains_contactor_cmd_ff};
  mbs_sequencer #(.BASE_DELAY_CYC(BASE), .WAIT_UNIT_CYC(UNIT)) DUT (.ref_clk, .reset_n,
    .clk_en(1'b1), .select_drive_mode_fifty, .select_drive_mode_sixty, .run_cmd_pin,
    .drive_alarm, .main_circuit_ready, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
    .reg_rd_data_ff, .mains_contactor_cmd_ff, .drive_input_contactor_cmd_ff,
    .drive_output_contactor_cmd_ff, .gate_enable_ff, .drive_run_ff, .resync_start_ff,
    .start_freq_hz_ff);
  mbs_partner u_far (.ref_clk, .powered, .input_cmd(drive_input_contactor_cmd_ff),
    .output_cmd(drive_output_contactor_cmd_ff), .mains_cmd(mains_contactor_cmd_ff),
    .main_circuit_ready, .overlap);
  always #50 ref_clk = ~ref_clk;
  task automatic end_of_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1 chk(n, e, reg_rd_data_ff);
  endtask
  // only one variant is ever raised at a time
  task automatic sel(logic on, logic six);
    @(posedge ref_clk);
    select_drive_mode_fifty <= on & !six;
    select_drive_mode_sixty <= on & six;
  endtask
  // bounded wait for an output bit, returns cycles spent
  task automatic wait_bit(int b, logic v, output int n);
    n = 0;
    #1;
    while (o[b] !== v && n < 400) begin
      tick(1);
      n++;
    end
    chk("wait", v, o[b]);
  endtask
  initial begin
    int n, w;
    tick(16);
    reset_n <= 1'b1;
    rd(4'h8, 32'h1, "status");
    rd(4'hc, 32'h0, "unmapped");
    for (int k = 0; k < 4; k++) begin
      w = $random(seed) & 3;
      powered <= k[1];
      wr(4'h4, w);
      wr(4'h0, {28'h0, !k[1], 3'b110});
      run_cmd_pin <= 1'b1;
      sel(1'b1, k[0]);
      wait_bit(2, 1'b1, n);
      chk("t2", 1, n >= BASE);
      chk("input", !k[1], o[1]);
      chk("freq", k[0] ? 7'h3c : 7'h32, start_freq_hz_ff);
      wait_bit(4, 1'b1, n);
      chk("t3", 1, n >= BASE + w * UNIT);
      tick(2);
      chk("drive", {2'b11, !k[1], 1'b0}, o[3:0]);
      sel(1'b0, k[0]);
      tick(8);
      chk("cut", 4'b0000, o[3:0]);
      wait_bit(0, 1'b1, n);
      chk("t1", 1, n + 8 >= BASE + w * UNIT);
      run_cmd_pin <= 1'b0;
      tick(8);
      chk("mains run", 0, o[0]);
      $display("test drive %0d done", k);
    end
    run_cmd_pin <= 1'b1;
    tick(8);
    sel(1'b1, 1'b0);
    tick(10);
    sel(1'b0, 1'b0);
    tick(BASE + 20);
    chk("toggle out", 0, o[2]);
    wait_bit(0, 1'b1, n);
    sel(1'b1, 1'b0);
    wait_bit(2, 1'b1, n);
    run_cmd_pin <= 1'b0;
    sel(1'b0, 1'b0);
    tick(BASE + 3 * UNIT + 20);
    chk("no run", 0, o[0]);
    run_cmd_pin <= 1'b1;
    tick(8);
    chk("late run", 1, o[0]);
    $display("test sequence done");
    sel(1'b1, 1'b0);
    wait_bit(4, 1'b1, n);
    tick(2);
    rd(4'h8, 32'h1c40, "status");
    drive_alarm <= 1'b1;
    tick(3);
    chk("alarm", 6'b000100, o);
    drive_alarm <= 1'b0;
    tick(3);
    chk("clear", 1, o[5]);
    wr(4'h0, 32'hf);
    drive_alarm <= 1'b1;
    tick(3);
    chk("fallback", 0, o[2]);
    drive_alarm <= 1'b0;
    wait_bit(0, 1'b1, n);
    $display("test alarm done");
    wr(4'h0, 32'h8);
    sel(1'b0, 1'b0);
    tick(8);
    chk("off", 5'b01000, o[4:0]);
    sel(1'b1, 1'b1);
    tick(8);
    chk("on", 5'b01000, o[4:0]);
    chk("overlap", 0, overlap);
    $display("test unassigned done");
    end_of_test();
  end
endmodule

// file: sim/mbs_chk.sv
module mbs_chk (
  input wire ref_clk,
  input wire reset_n,
  input wire drive_alarm,
  input wire main_circuit_ready,
  input wire mains_contactor_cmd_ff,
  input wire drive_input_contactor_cmd_ff,
  input wire drive_output_contactor_cmd_ff,
  input wire gate_enable_ff,
  input wire drive_run_ff,
  input wire resync_start_ff,
  input wire [6:0] start_freq_hz_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire mc = mains_contactor_cmd_ff;
  wire ic = drive_input_contactor_cmd_ff;
  wire oc = drive_output_contactor_cmd_ff;
  // the 20-cycle depths match the shortened base delay of the bench
  property p_cut; $fell(oc) |-> !gate_enable_ff && !drive_run_ff; endproperty
  a_cut: assert property (p_cut) else $error("gate on as output opened");
  property p_in_cut; $fell(ic) |-> !oc && !gate_enable_ff; endproperty
  a_in_cut: assert property (p_in_cut) else $error("input opened alone");
  property p_mains_wait; $rose(mc) |-> !$past(oc, 20); endproperty
  a_mains_wait: assert property (p_mains_wait) else $error("mains closed early");
  property p_in_mains; $rose(ic) |-> !mc; endproperty
  a_in_mains: assert property (p_in_mains) else $error("mains held with input");
  property p_out_rdy; $rose(oc) |-> $past(main_circuit_ready) && ic == $past(ic, 20); endproperty
  a_out_rdy: assert property (p_out_rdy) else $error("output closed early");
  property p_resync; $rose(resync_start_ff) |-> $past(oc, 20) && !mc; endproperty
  a_resync: assert property (p_resync) else $error("resync too early");
  property p_pulse; resync_start_ff |=> !resync_start_ff; endproperty
  a_pulse: assert property (p_pulse) else $error("resync pulse too long");
  property p_freq; start_freq_hz_ff == 7'h32 || start_freq_hz_ff == 7'h3c; endproperty
  a_freq: assert property (p_freq) else $error("bad start frequency");
  property p_alarm; drive_alarm && oc |-> ##[1:3] !drive_run_ff; endproperty
  a_alarm: assert property (p_alarm) else $error("ran on with alarm");
  property p_excl; !(mc && oc); endproperty
  a_excl: assert property (p_excl) else $error("mains and output closed");
endmodule

bind mbs_sequencer mbs_chk u_chk (.ref_clk, .reset_n, .drive_alarm, .main_circuit_ready,
  .mains_contactor_cmd_ff, .drive_input_contactor_cmd_ff, .drive_output_contactor_cmd_ff,
  .gate_enable_ff, .drive_run_ff, .resync_start_ff, .start_freq_hz_ff);

// file: sim/mbs_partner.sv
module mbs_partner #(
  parameter int READY_CYC = 7
) (
  input wire ref_clk,
  input wire powered,
  input wire input_cmd,
  input wire output_cmd,
  input wire mains_cmd,
  output logic main_circuit_ready = 1'b0,
  output logic overlap = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // dc link charges only while power reaches it
  always @(posedge ref_clk) begin
    if (!(input_cmd || powered)) cnt <= 0;
    else if (cnt < READY_CYC) cnt <= cnt + 1;
    main_circuit_ready <= (cnt == READY_CYC);
    // outside interlock: both closed would back-feed the output stage
    if (mains_cmd && output_cmd) overlap <= 1'b1;
  end
endmodule
